// file: verilog/alu_ops_core.sv
// Execution datapath for subtract, swap, xor and direction-load operations
//
// Summary of operation
// - Subtract W from file, two's complement
// - d=0 writes W, d=1 writes file
// - Carry and half carry mean no borrow
// - Subtract W and borrow from file
// - Swap file nibbles, status untouched
// - Omitted destination defaults to file for borrow subtract and swap only
// - Load direction register 5,6,7 from W
// - XOR literal into W, zero only
// - XOR W with file, zero only
`timescale 1ns/1ns
`include "alu_ops_regs.svh"
module alu_ops_core
#(
  parameter int WIDTH = 8
)
(
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 exec_in,
  input  wire alu_ops_pkg::alu_op_t op_in,
  input  wire logic [6:0]           file_addr_in,
  input  wire logic                 dest_in,
  input  wire logic                 dest_given_in,
  input  wire logic [WIDTH-1:0]     file_data_in,
  input  wire logic [WIDTH-1:0]     literal_in,
  input  wire logic [7:0]           reg_addr_in,
  input  wire logic [WIDTH-1:0]     reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output logic      [WIDTH-1:0]     reg_rdata_out,
  output logic                      file_we_out,
  output logic      [6:0]           file_waddr_out,
  output logic      [WIDTH-1:0]     file_wdata_out,
  output logic      [WIDTH-1:0]     w_out,
  output logic      [2:0]           status_out,
  output logic      [WIDTH-1:0]     port_a_direction_out,
  output logic      [WIDTH-1:0]     port_b_direction_out,
  output logic      [WIDTH-1:0]     port_c_direction_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [WIDTH-1:0] w_ff;
  logic             carry_ff;
  logic             half_ff;
  logic             zero_ff;
  logic [WIDTH-1:0] dir_a_ff;
  logic [WIDTH-1:0] dir_b_ff;
  logic [WIDTH-1:0] dir_c_ff;
  logic [WIDTH-1:0] result_ff;
  logic [WIDTH-1:0] rdata_ff;
  logic             file_we_ff;
  logic [6:0]       file_waddr_ff;
  logic [WIDTH-1:0] file_wdata_ff;

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  wire is_subtract_w_from_file  = exec_in && (op_in == alu_ops_pkg::op_sub_w_from_file);
  wire is_subb   = exec_in && (op_in == alu_ops_pkg::op_sub_with_borrow);
  wire is_swap   = exec_in && (op_in == alu_ops_pkg::op_nibble_swap);
  wire is_dir    = exec_in && (op_in == alu_ops_pkg::op_load_direction);
  wire is_xorl   = exec_in && (op_in == alu_ops_pkg::op_xor_literal);
  wire is_xorf   = exec_in && (op_in == alu_ops_pkg::op_xor_w_file);
  wire file_op   = is_subtract_w_from_file || is_subb || is_swap || is_xorf;
  wire addr_ok   = (file_addr_in <= `FILE_ADDR_MAX);

  // Omitted selector falls back to the file only where allowed
  wire dflt_ok   = is_subb || is_swap;
  wire dest_file = (dest_given_in || !dflt_ok) ? dest_in : 1'b1;

  // ****************************************************************
  // Arithmetic
  // ****************************************************************
  wire [WIDTH-1:0] sub_diff;
  wire             sub_carry;
  wire             sub_half;

  // Plain subtract forces carry in high; borrow form uses stored carry
  wire sub_cin = is_subb ? carry_ff : 1'b1;

  sub_borrow_unit #(.WIDTH(WIDTH)) u_sub
  (
    .minuend_in     (file_data_in),
    .subtrahend_in  (w_ff),
    .carry_in       (sub_cin),
    .diff_out       (sub_diff),
    .carry_out      (sub_carry),
    .half_carry_out (sub_half)
  );

  wire [WIDTH-1:0] swap_val = {file_data_in[3:0], file_data_in[7:4]};
  wire [WIDTH-1:0] xorl_val = w_ff ^ literal_in;
  wire [WIDTH-1:0] xorf_val = w_ff ^ file_data_in;

  // Result mux
  wire [WIDTH-1:0] alu_val  = (is_subtract_w_from_file || is_subb) ? sub_diff :
                              is_swap ? swap_val :
                              is_xorl ? xorl_val :
                              is_xorf ? xorf_val : w_ff;
  wire res_zero = (alu_val == {WIDTH{1'b0}});

  // Destination steering
  wire to_file  = file_op && addr_ok && dest_file;
  wire to_w     = is_xorl || (file_op && addr_ok && !dest_file);
  wire upd_cdc  = (is_subtract_w_from_file || is_subb) && addr_ok;
  wire upd_z    = upd_cdc || is_xorl || (is_xorf && addr_ok);

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  wire wr_w     = reg_wr_in && (reg_addr_in == `REG_W_OFFSET);
  wire wr_stat  = reg_wr_in && (reg_addr_in == `REG_STATUS_OFFSET);
  wire wr_dir_a = reg_wr_in && (reg_addr_in == `REG_DIR_A_OFFSET);
  wire wr_dir_b = reg_wr_in && (reg_addr_in == `REG_DIR_B_OFFSET);
  wire wr_dir_c = reg_wr_in && (reg_addr_in == `REG_DIR_C_OFFSET);

  // Direction load selection, other operands ignored
  wire ld_a     = is_dir && (file_addr_in == `DIR_SEL_A);
  wire ld_b     = is_dir && (file_addr_in == `DIR_SEL_B);
  wire ld_c     = is_dir && (file_addr_in == `DIR_SEL_C);

  wire [2:0] status_now = {zero_ff, half_ff, carry_ff};

  // Read mux; unmapped addresses answer zero
  logic [WIDTH-1:0] nxt_rdata;
  always_comb
  begin
    if (reg_addr_in == `REG_W_OFFSET)
      nxt_rdata = w_ff;
    else if (reg_addr_in == `REG_STATUS_OFFSET)
      nxt_rdata = {{(WIDTH-3){1'b0}}, status_now};
    else if (reg_addr_in == `REG_DIR_A_OFFSET)
      nxt_rdata = dir_a_ff;
    else if (reg_addr_in == `REG_DIR_B_OFFSET)
      nxt_rdata = dir_b_ff;
    else if (reg_addr_in == `REG_DIR_C_OFFSET)
      nxt_rdata = dir_c_ff;
    else if (reg_addr_in == `REG_RESULT_OFFSET)
      nxt_rdata = result_ff;
    else
      nxt_rdata = {WIDTH{1'b0}};
  end

  // ****************************************************************
  // W and status
  // ****************************************************************
  // Instruction execution wins over a software write in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      w_ff     <= `W_RESET;
      carry_ff <= 1'b0;
      half_ff  <= 1'b0;
      zero_ff  <= 1'b0;
    end
    else
    begin
      if (to_w)
        w_ff <= alu_val;
      else if (wr_w)
        w_ff <= reg_wdata_in;
      if (upd_cdc)
      begin
        carry_ff <= sub_carry;
        half_ff  <= sub_half;
      end
      else if (wr_stat)
      begin
        carry_ff <= reg_wdata_in[`STATUS_CARRY_BIT];
        half_ff  <= reg_wdata_in[`STATUS_HALF_BIT];
      end
      if (upd_z)
        zero_ff <= res_zero;
      else if (wr_stat)
        zero_ff <= reg_wdata_in[`STATUS_ZERO_BIT];
    end
  end

  // ****************************************************************
  // Port direction registers
  // ****************************************************************
  // Reset to all inputs so pins float safe until software acts
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dir_a_ff <= `DIR_RESET;
      dir_b_ff <= `DIR_RESET;
      dir_c_ff <= `DIR_RESET;
    end
    else
    begin
      if (ld_a)
        dir_a_ff <= w_ff;
      else if (wr_dir_a)
        dir_a_ff <= reg_wdata_in;
      if (ld_b)
        dir_b_ff <= w_ff;
      else if (wr_dir_b)
        dir_b_ff <= reg_wdata_in;
      if (ld_c)
        dir_c_ff <= w_ff;
      else if (wr_dir_c)
        dir_c_ff <= reg_wdata_in;
    end
  end

  // ****************************************************************
  // File write-back and read port
  // ****************************************************************
  // Write-back is registered; memory sees it one cycle after exec
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      file_we_ff    <= 1'b0;
      file_waddr_ff <= 7'h00;
      file_wdata_ff <= {WIDTH{1'b0}};
      result_ff     <= {WIDTH{1'b0}};
      rdata_ff      <= {WIDTH{1'b0}};
    end
    else
    begin
      file_we_ff    <= to_file;
      file_waddr_ff <= file_addr_in;
      file_wdata_ff <= alu_val;
      if (to_file || to_w)
        result_ff <= alu_val;
      rdata_ff      <= reg_rd_in ? nxt_rdata : {WIDTH{1'b0}};
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_out        = rdata_ff;
  assign file_we_out          = file_we_ff;
  assign file_waddr_out       = file_waddr_ff;
  assign file_wdata_out       = file_wdata_ff;
  assign w_out                = w_ff;
  assign status_out           = status_now;
  assign port_a_direction_out = dir_a_ff;
  assign port_b_direction_out = dir_b_ff;
  assign port_c_direction_out = dir_c_ff;

endmodule

// file: verilog/alu_ops_regs.svh
// Constants for the subtract, swap, xor and direction-load datapath
`ifndef ALU_OPS_REGS_SVH
`define ALU_OPS_REGS_SVH

// ****************************************************************
// Register offsets (plain register port, word per offset)
// ****************************************************************
`define REG_W_OFFSET        8'h00
`define REG_STATUS_OFFSET   8'h01
`define REG_DIR_A_OFFSET    8'h02
`define REG_DIR_B_OFFSET    8'h03
`define REG_DIR_C_OFFSET    8'h04
`define REG_RESULT_OFFSET   8'h05

// ****************************************************************
// Status field positions
// ****************************************************************
`define STATUS_CARRY_BIT    0
`define STATUS_HALF_BIT     1
`define STATUS_ZERO_BIT     2

// ****************************************************************
// Reset values and operand codes
// ****************************************************************
`define W_RESET             8'h00
`define STATUS_RESET        3'h0
`define DIR_RESET           8'hff
`define DIR_SEL_A           7'h05
`define DIR_SEL_B           7'h06
`define DIR_SEL_C           7'h07
`define FILE_ADDR_MAX       7'h7f

`endif

// file: verilog/alu_ops_pkg.sv
// Types shared by the datapath files
package alu_ops_pkg;

  // Operation selected by the instruction decoder
  typedef enum logic [2:0]
  {
    op_none_t_v,
    op_sub_w_from_file,
    op_sub_with_borrow,
    op_nibble_swap,
    op_load_direction,
    op_xor_literal,
    op_xor_w_file
  } alu_op_t;

endpackage

// file: verilog/sub_borrow_unit.sv
// Eight-bit subtractor giving difference, carry and half carry
`timescale 1ns/1ns
module sub_borrow_unit
#(
  parameter int WIDTH = 8
)
(
  input  wire logic [WIDTH-1:0] minuend_in,
  input  wire logic [WIDTH-1:0] subtrahend_in,
  input  wire logic             carry_in,
  output logic      [WIDTH-1:0] diff_out,
  output logic                  carry_out,
  output logic                  half_carry_out
);

  // Two's complement: a + ~b + carry; carry high means no borrow
  logic [WIDTH:0] full_sum;
  logic [4:0]     low_sum;

  assign full_sum       = {1'b0, minuend_in} + {1'b0, ~subtrahend_in} + {{WIDTH{1'b0}}, carry_in};
  assign low_sum        = {1'b0, minuend_in[3:0]} + {1'b0, ~subtrahend_in[3:0]}
                          + {4'h0, carry_in};
  assign diff_out       = full_sum[WIDTH-1:0];
  assign carry_out      = full_sum[WIDTH];
  assign half_carry_out = low_sum[4];

endmodule

// file: tb/alu_ops_monitor.sv
// Checker on the ports of the subtract, swap, xor and direction-load datapath
`timescale 1ns/1ns
module alu_ops_monitor
(
  input wire logic                 clk_in,
  input wire logic                 rst_in,
  input wire logic                 exec_in,
  input wire alu_ops_pkg::alu_op_t op_in,
  input wire logic [6:0]           file_addr_in,
  input wire logic                 dest_in,
  input wire logic                 dest_given_in,
  input wire logic [7:0]           file_data_in,
  input wire logic [7:0]           literal_in,
  input wire logic                 reg_wr_in,
  input wire logic                 file_we_out,
  input wire logic [7:0]           file_wdata_out,
  input wire logic [7:0]           w_out,
  input wire logic [2:0]           status_out,
  input wire logic [7:0]           port_a_direction_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Decoded strobes; register writes excluded where they may win a field
  wire logic sub_go = exec_in && op_in == alu_ops_pkg::op_sub_w_from_file;
  wire logic sbb_go = exec_in && op_in == alu_ops_pkg::op_sub_with_borrow;
  wire logic swp_go = exec_in && op_in == alu_ops_pkg::op_nibble_swap;
  wire logic dir_go = exec_in && op_in == alu_ops_pkg::op_load_direction && !reg_wr_in;
  wire logic xl_go  = exec_in && op_in == alu_ops_pkg::op_xor_literal && !reg_wr_in;
  wire logic xf_go  = exec_in && op_in == alu_ops_pkg::op_xor_w_file;
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_sub;
    sub_go && dest_in |=> file_we_out && file_wdata_out == $past(file_data_in) - $past(w_out);
  endproperty
  a_sub: assert property (p_sub) else $error("subtract result wrong");
  property p_subf;
    sub_go && !reg_wr_in |=> status_out[1:0] == {$past(w_out[3:0]) <= $past(file_data_in[3:0]),
                                                 $past(w_out) <= $past(file_data_in)};
  endproperty
  a_subf: assert property (p_subf) else $error("subtract flags wrong");
  property p_sbb;
    sbb_go && !dest_given_in |=> file_we_out && file_wdata_out ==
      $past(file_data_in) - $past(w_out) - {7'h00, !$past(status_out[0])};
  endproperty
  a_sbb: assert property (p_sbb) else $error("borrow subtract wrong");
  property p_swp;
    swp_go && !dest_given_in |=> file_we_out &&
      file_wdata_out == {$past(file_data_in[3:0]), $past(file_data_in[7:4])};
  endproperty
  a_swp: assert property (p_swp) else $error("swap result wrong");
  property p_swpf;
    swp_go && !reg_wr_in |=> $stable(status_out);
  endproperty
  a_swpf: assert property (p_swpf) else $error("swap changed status");
  property p_dir;
    dir_go && file_addr_in == 7'h05 |-> ##1 port_a_direction_out == $past(w_out);
  endproperty
  a_dir: assert property (p_dir) else $error("direction load wrong");
  property p_xl;
    xl_go |=> w_out == ($past(w_out) ^ $past(literal_in)) && status_out[2] == (w_out == 8'h00)
      && $stable(status_out[1:0]);
  endproperty
  a_xl: assert property (p_xl) else $error("xor literal wrong");
  property p_xf;
    xf_go && !dest_in |=> w_out == ($past(w_out) ^ $past(file_data_in)) && !file_we_out;
  endproperty
  a_xf: assert property (p_xf) else $error("xor file wrong");
  c_sub: cover property (sub_go && dest_in);
  c_swp: cover property (swp_go && !dest_given_in);
  c_dir: cover property (dir_go);
endmodule
bind alu_ops_core alu_ops_monitor alu_ops_monitor_inst (.*);

// file: tb/subtract_swap_xor_alu_ops_tb_top.sv
// Self-checking bench for the subtract, swap, xor and direction-load datapath
`timescale 1ns/1ns
module subtract_swap_xor_alu_ops_tb_top;
  logic                 clk_in, rst_in = 1'b1, exec_in = 1'b0, reg_wr_in = 1'b0;
  logic                 dest_in = 1'b0, dest_given_in = 1'b0, reg_rd_in = 1'b0;
  alu_ops_pkg::alu_op_t op_in = alu_ops_pkg::op_none_t_v;
  logic [6:0]           file_addr_in = 7'h00, file_waddr_out;
  logic [7:0]           file_data_in = 8'h00, literal_in = 8'h00;
  logic [7:0]           reg_addr_in = 8'h00, reg_wdata_in = 8'h00;
  logic [7:0]           reg_rdata_out, file_wdata_out, w_out;
  logic [7:0]           port_a_direction_out, port_b_direction_out, port_c_direction_out;
  logic [2:0]           status_out;
  logic                 file_we_out;
  int                   errors = 0, n_tests = 0, cyc = 0;
  alu_ops_core alu_ops_core_inst (.*);
  // 25 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // Hang guard; the whole run needs about sixty cycles
  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 1000)
    begin
      errors++;
      close_out();
    end
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(reg_rdata_out, e);
  endtask
  // One instruction, outputs sampled just after the answering edge
  task automatic run(input alu_ops_pkg::alu_op_t o, input logic [6:0] a, input logic d, g,
                     input logic [7:0] f, k);
    @(posedge clk_in);
    exec_in <= 1'b1;
    op_in <= o;
    file_addr_in <= a;
    dest_in <= d;
    dest_given_in <= g;
    file_data_in <= f;
    literal_in <= k;
    @(posedge clk_in);
    exec_in <= 1'b0;
    #1;
  endtask
  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_sub();
    wr(8'h00, 8'h03);
    run(alu_ops_pkg::op_sub_w_from_file, 7'h12, 1'b1, 1'b1, 8'h05, 8'h00);
    chk({7'h00, file_we_out}, 8'h01);
    chk(file_wdata_out, 8'h02);
    chk({5'h00, status_out}, 8'h03);
    wr(8'h00, 8'h06);
    run(alu_ops_pkg::op_sub_w_from_file, 7'h12, 1'b0, 1'b1, 8'h05, 8'h00);
    chk(w_out, 8'hff);
    chk({5'h00, status_out}, 8'h00);
    $display("sub done");
  endtask
  task automatic t_borrow();
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h01);
    run(alu_ops_pkg::op_sub_with_borrow, 7'h7f, 1'b0, 1'b0, 8'h10, 8'h00);
    chk({file_we_out, file_waddr_out}, 8'hff);
    chk(file_wdata_out, 8'h0e);
    chk({5'h00, status_out}, 8'h01);
    run(alu_ops_pkg::op_sub_with_borrow, 7'h00, 1'b0, 1'b1, 8'h01, 8'h00);
    chk(w_out, 8'h00);
    chk({5'h00, status_out}, 8'h07);
    $display("borrow done");
  endtask
  task automatic t_swap();
    run(alu_ops_pkg::op_nibble_swap, 7'h03, 1'b0, 1'b0, 8'ha5, 8'h00);
    chk(file_wdata_out, 8'h5a);
    chk({5'h00, status_out}, 8'h07);
    run(alu_ops_pkg::op_nibble_swap, 7'h03, 1'b0, 1'b1, 8'hc3, 8'h00);
    chk(w_out, 8'h3c);
    $display("swap done");
  endtask
  task automatic t_dir();
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h00, 8'h30 + 8'(i));
      run(alu_ops_pkg::op_load_direction, 7'h05 + 7'(i), 1'b0, 1'b0, 8'h00, 8'h00);
    end
    wr(8'h00, 8'h77);
    run(alu_ops_pkg::op_load_direction, 7'h04, 1'b0, 1'b0, 8'h00, 8'h00);
    chk(port_a_direction_out, 8'h30);
    chk(port_b_direction_out, 8'h31);
    chk(port_c_direction_out, 8'h32);
    chk({5'h00, status_out}, 8'h07);
    $display("direction done");
  endtask
  task automatic t_xor();
    wr(8'h00, 8'h5a);
    run(alu_ops_pkg::op_xor_literal, 7'h00, 1'b1, 1'b1, 8'h00, 8'h5a);
    chk({status_out, 5'h00} | w_out, 8'he0);
    run(alu_ops_pkg::op_xor_literal, 7'h00, 1'b1, 1'b1, 8'h00, 8'hff);
    chk({status_out, 5'h00} | w_out, 8'hff);
    run(alu_ops_pkg::op_xor_w_file, 7'h09, 1'b1, 1'b1, 8'h0f, 8'h00);
    chk(file_wdata_out, 8'hf0);
    run(alu_ops_pkg::op_xor_w_file, 7'h09, 1'b0, 1'b1, 8'hff, 8'h00);
    chk({status_out, 5'h00} | w_out, 8'he0);
    rdc(8'h05, 8'h00);
    rdc(8'h01, 8'h07);
    $display("xor done");
  endtask
  // Main sequence: reset, reset values, unmapped read, then each scenario
  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rdc(8'h00, 8'h00);
    rdc(8'h04, 8'hff);
    rdc(8'h09, 8'h00);
    $display("reset done");
    t_sub();
    t_borrow();
    t_swap();
    t_dir();
    t_xor();
    close_out();
  end
endmodule
